// ### pllc_pkg.sv
`default_nettype none
package pllc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS     = 12'h000;
    localparam logic [11:0] UPDATE_OFS   = 12'h004;
    localparam logic [11:0] ACTIVE_OFS   = 12'h008;
    localparam logic [11:0] STATUS_OFS   = 12'h00c;

    // ------------------------------------------------------------------
    // Control field layout and reset value
    // ------------------------------------------------------------------
    localparam int          CTRL_W       = 7;
    localparam int          CNT_SEL_LSB  = 5;
    localparam int          WIN_SEL_BIT  = 4;
    localparam int          DIS_BIT      = 3;
    localparam int          CAL_DIV_LSB  = 1;
    localparam int          CAL_NOW_BIT  = 0;
    localparam int          UPDATE_BIT   = 0;
    localparam logic [6:0]  CTRL_RST     = 7'h06;

    // Status field layout
    localparam int          ST_LOCK_BIT  = 0;
    localparam int          ST_BUSY_BIT  = 1;
    localparam int          ST_RUN_LSB   = 8;

    // ------------------------------------------------------------------
    // Lock counter targets and calibration divide ratios
    // ------------------------------------------------------------------
    localparam logic [7:0]  LOCK_CNT_00  = 8'h05;
    localparam logic [7:0]  LOCK_CNT_01  = 8'h10;
    localparam logic [7:0]  LOCK_CNT_10  = 8'h40;
    localparam logic [7:0]  LOCK_CNT_11  = 8'hff;
    localparam logic [4:0]  CAL_DIV_00   = 5'h02;
    localparam logic [4:0]  CAL_DIV_01   = 5'h04;
    localparam logic [4:0]  CAL_DIV_10   = 5'h08;
    localparam logic [4:0]  CAL_DIV_11   = 5'h10;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam real         CLK_PERIOD_NS   = 5.0;
    localparam real         LOCK_WIN_HI_NS  = 3.5;
    localparam real         LOCK_WIN_LO_NS  = 2.0;
    localparam int          WIN_HI_CYC      = (LOCK_WIN_HI_NS < CLK_PERIOD_NS) ? 1 :
                                              int'($floor(LOCK_WIN_HI_NS / CLK_PERIOD_NS));
    localparam int          WIN_LO_CYC      = (LOCK_WIN_LO_NS < CLK_PERIOD_NS) ? 1 :
                                              int'($floor(LOCK_WIN_LO_NS / CLK_PERIOD_NS));
    localparam logic [7:0]  WIN_HI          = 8'(WIN_HI_CYC);
    localparam logic [7:0]  WIN_LO          = 8'(WIN_LO_CYC);
    localparam logic [7:0]  LOL_MARGIN      = 8'h01;
    localparam logic [7:0]  GAP_MAX         = 8'hff;
    localparam logic [7:0]  CAL_LEN         = 8'h20;

    typedef enum logic [1:0] {
        ME_IDLE     = 2'b00,
        ME_WAIT_FB  = 2'b01,
        ME_WAIT_REF = 2'b10
    } pllc_meas_e;

endpackage : pllc_pkg
`default_nettype wire

// ### pllc_cal_div.sv
`default_nettype none
module pllc_cal_div (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ref_rise,
    input  wire logic [1:0] div_sel,
    output logic            cal_clk,
    output logic            cal_tick
);

    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic       clk_ff;
    logic       nxt_clk;
    logic       tick_ff;
    logic       nxt_tick;
    logic [4:0] ratio;
    logic [3:0] last;
    logic [3:0] half;

    function automatic logic [4:0] div_ratio(input logic [1:0] sel);
        unique case (sel)
            2'b00: div_ratio = pllc_pkg::CAL_DIV_00;
            2'b01: div_ratio = pllc_pkg::CAL_DIV_01;
            2'b10: div_ratio = pllc_pkg::CAL_DIV_10;
            2'b11: div_ratio = pllc_pkg::CAL_DIV_11;
        endcase
    endfunction : div_ratio

    // Count reference edges; high for the first half of each period
    always_comb begin
        ratio    = div_ratio(div_sel);
        last     = 4'(ratio - 5'h01);
        half     = 4'(ratio >> 1);
        nxt_cnt  = cnt_ff;
        nxt_tick = 1'b0;
        if (ref_rise) begin
            if (cnt_ff >= last) begin
                nxt_cnt  = 4'h0;
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 4'h1;
            end
        end
        nxt_clk = (nxt_cnt < half);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 4'h0;
            clk_ff  <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            clk_ff  <= nxt_clk;
            tick_ff <= nxt_tick;
        end
    end

    assign cal_clk  = clk_ff;
    assign cal_tick = tick_ff;

endmodule : pllc_cal_div
`default_nettype wire

// ### pllc_top.sv
// Contract
// - Lock is declared only after 5, 16, 64 or 255 consecutive in-window detector cycles, chosen by a 2-bit field.
// - The lock flag is set when the edge gap between the two detector inputs is below the lock window.
// - Once set, the lock flag holds until the edge gap exceeds the loss-of-lock threshold.
// - A window select bit picks the high range (default, 3.5 ns) at 0 or the low range at 1; here both ranges round up to one 5 ns clock cycle.
// - A disable bit at 1 turns lock detection off; 0 (default) keeps it running.
// - The calibration clock is the reference divided by 2, 4, 8 or 16 (default) per a 2-bit field.
// - A calibration starts only when the active calibrate-now bit goes from 0 to 1; it resets to 0.
//
// Chosen here: the APB register port and the placing of the registers.
`default_nettype none
module pllc_top (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        pfd_ref_in,
    input  wire logic        pfd_fb_in,
    input  wire logic        ref_clk_in,
    output logic             digital_lock_flag,
    output logic             cal_clk,
    output logic             cal_busy
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic       rst_meta_ff;
    logic       rst_n_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers: 0 ref, 1 feedback, 2 reference clock
    // ------------------------------------------------------------------
    logic [2:0] pin_in;
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] lvl_ff;
    logic [2:0] rise;

    assign pin_in = {ref_clk_in, pfd_fb_in, pfd_ref_in};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge clk_sys or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                s1_ff[i]  <= 1'b0;
                s2_ff[i]  <= 1'b0;
                s3_ff[i]  <= 1'b0;
                lvl_ff[i] <= 1'b0;
            end else begin
                s1_ff[i]  <= pin_in[i];
                s2_ff[i]  <= s1_ff[i];
                s3_ff[i]  <= s2_ff[i];
                lvl_ff[i] <= (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
            end
        end
        assign rise[i] = (s2_ff[i] == s3_ff[i]) && s3_ff[i] && !lvl_ff[i];
    end

    // ------------------------------------------------------------------
    // APB slave and registers
    // ------------------------------------------------------------------
    logic [6:0]  ctrl_ff;
    logic [6:0]  nxt_ctrl;
    logic [6:0]  act_ff;
    logic [6:0]  nxt_act;
    logic        rdy_ff;
    logic        nxt_rdy;
    logic        err_ff;
    logic        nxt_err;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        acc_first;
    logic        acc_done;
    logic        transfer;
    logic        cal_trig;
    logic        lock_ff;
    logic        busy_ff;
    logic [7:0]  run_ff;

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
        reg_hit = (a[11:2] == ofs[11:2]);
    endfunction : reg_hit

    always_comb begin
        acc_first = psel && penable && !rdy_ff;
        acc_done  = psel && penable && rdy_ff;
        nxt_rdy   = acc_first;
        nxt_err   = acc_first && !(reg_hit(paddr, pllc_pkg::CTRL_OFS) || reg_hit(paddr, pllc_pkg::UPDATE_OFS) ||
                                   reg_hit(paddr, pllc_pkg::ACTIVE_OFS) || reg_hit(paddr, pllc_pkg::STATUS_OFS));
        nxt_rdata = rdata_ff;
        if (acc_first && !pwrite) begin
            nxt_rdata = 32'h0000_0000;
            if (reg_hit(paddr, pllc_pkg::CTRL_OFS)) begin
                nxt_rdata[pllc_pkg::CTRL_W-1:0] = ctrl_ff;
            end else if (reg_hit(paddr, pllc_pkg::ACTIVE_OFS)) begin
                nxt_rdata[pllc_pkg::CTRL_W-1:0] = act_ff;
            end else if (reg_hit(paddr, pllc_pkg::STATUS_OFS)) begin
                nxt_rdata[pllc_pkg::ST_LOCK_BIT]              = lock_ff;
                nxt_rdata[pllc_pkg::ST_BUSY_BIT]              = busy_ff;
                nxt_rdata[pllc_pkg::ST_RUN_LSB+7:pllc_pkg::ST_RUN_LSB] = run_ff;
            end
        end
        nxt_ctrl = ctrl_ff;
        if (acc_done && pwrite && pstrb[0] && reg_hit(paddr, pllc_pkg::CTRL_OFS)) begin
            nxt_ctrl = pwdata[pllc_pkg::CTRL_W-1:0];
        end
        // Transfer strobe moves the staged settings into the active copy
        transfer = acc_done && pwrite && pstrb[0] && pwdata[pllc_pkg::UPDATE_BIT] &&
                   reg_hit(paddr, pllc_pkg::UPDATE_OFS);
        nxt_act  = transfer ? ctrl_ff : act_ff;
        cal_trig = nxt_act[pllc_pkg::CAL_NOW_BIT] && !act_ff[pllc_pkg::CAL_NOW_BIT];
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ctrl_ff  <= pllc_pkg::CTRL_RST;
            act_ff   <= pllc_pkg::CTRL_RST;
            rdy_ff   <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            act_ff   <= nxt_act;
            rdy_ff   <= nxt_rdy;
            err_ff   <= nxt_err;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Edge gap measurement between the two detector inputs
    // ------------------------------------------------------------------
    pllc_pkg::pllc_meas_e meas_st_ff;
    pllc_pkg::pllc_meas_e nxt_meas_st;
    logic [7:0] gap_ff;
    logic [7:0] nxt_gap;
    logic       meas_vld;
    logic [7:0] meas_diff;

    always_comb begin
        nxt_meas_st = meas_st_ff;
        nxt_gap     = gap_ff;
        meas_vld    = 1'b0;
        meas_diff   = gap_ff;
        unique case (meas_st_ff)
            pllc_pkg::ME_IDLE: begin
                nxt_gap = 8'h01;
                if (rise[0] && rise[1]) begin
                    meas_vld  = 1'b1;
                    meas_diff = 8'h00;
                end else if (rise[0]) begin
                    nxt_meas_st = pllc_pkg::ME_WAIT_FB;
                end else if (rise[1]) begin
                    nxt_meas_st = pllc_pkg::ME_WAIT_REF;
                end
            end
            pllc_pkg::ME_WAIT_FB, pllc_pkg::ME_WAIT_REF: begin
                if ((meas_st_ff == pllc_pkg::ME_WAIT_FB) ? rise[1] : rise[0]) begin
                    meas_vld    = 1'b1;
                    nxt_meas_st = pllc_pkg::ME_IDLE;
                end else if (rise[0] || rise[1] || gap_ff == pllc_pkg::GAP_MAX) begin
                    // Missing partner edge counts as a gap beyond any threshold
                    meas_vld    = 1'b1;
                    meas_diff   = pllc_pkg::GAP_MAX;
                    nxt_meas_st = pllc_pkg::ME_IDLE;
                end else begin
                    nxt_gap = gap_ff + 8'h01;
                end
            end
            default: begin
                nxt_meas_st = pllc_pkg::ME_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            meas_st_ff <= pllc_pkg::ME_IDLE;
            gap_ff     <= 8'h01;
        end else begin
            meas_st_ff <= nxt_meas_st;
            gap_ff     <= nxt_gap;
        end
    end

    // ------------------------------------------------------------------
    // Lock decision with hysteresis
    // ------------------------------------------------------------------
    logic [7:0] nxt_run;
    logic       nxt_lock;
    logic [7:0] target;
    logic [7:0] win;
    logic [7:0] lol;

    function automatic logic [7:0] lock_target(input logic [1:0] sel);
        unique case (sel)
            2'b00: lock_target = pllc_pkg::LOCK_CNT_00;
            2'b01: lock_target = pllc_pkg::LOCK_CNT_01;
            2'b10: lock_target = pllc_pkg::LOCK_CNT_10;
            2'b11: lock_target = pllc_pkg::LOCK_CNT_11;
        endcase
    endfunction : lock_target

    always_comb begin
        target   = lock_target(act_ff[pllc_pkg::CNT_SEL_LSB+1:pllc_pkg::CNT_SEL_LSB]);
        win      = act_ff[pllc_pkg::WIN_SEL_BIT] ? pllc_pkg::WIN_LO : pllc_pkg::WIN_HI;
        lol      = win + pllc_pkg::LOL_MARGIN;
        nxt_run  = run_ff;
        nxt_lock = lock_ff;
        if (act_ff[pllc_pkg::DIS_BIT]) begin
            nxt_run  = 8'h00;
            nxt_lock = 1'b0;
        end else if (meas_vld) begin
            if (meas_diff < win) begin
                nxt_run = (run_ff >= target) ? run_ff : run_ff + 8'h01;
                if (nxt_run >= target) begin
                    nxt_lock = 1'b1;
                end
            end else begin
                nxt_run = 8'h00;
                if (meas_diff > lol) begin
                    nxt_lock = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            run_ff  <= 8'h00;
            lock_ff <= 1'b0;
        end else begin
            run_ff  <= nxt_run;
            lock_ff <= nxt_lock;
        end
    end

    // ------------------------------------------------------------------
    // Calibration clock and calibration run
    // ------------------------------------------------------------------
    logic       cal_tick;
    logic [7:0] cal_cnt_ff;
    logic [7:0] nxt_cal_cnt;
    logic       nxt_busy;

    pllc_cal_div u_cal_div (
        .clk      (clk_sys),
        .rst_n    (rst_n_ff),
        .ref_rise (rise[2]),
        .div_sel  (act_ff[pllc_pkg::CAL_DIV_LSB+1:pllc_pkg::CAL_DIV_LSB]),
        .cal_clk  (cal_clk),
        .cal_tick (cal_tick)
    );

    always_comb begin
        nxt_busy    = busy_ff;
        nxt_cal_cnt = cal_cnt_ff;
        if (cal_trig && !busy_ff) begin
            nxt_busy    = 1'b1;
            nxt_cal_cnt = 8'h00;
        end else if (busy_ff && cal_tick) begin
            nxt_cal_cnt = cal_cnt_ff + 8'h01;
            if (nxt_cal_cnt >= pllc_pkg::CAL_LEN) begin
                nxt_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            busy_ff    <= 1'b0;
            cal_cnt_ff <= 8'h00;
        end else begin
            busy_ff    <= nxt_busy;
            cal_cnt_ff <= nxt_cal_cnt;
        end
    end

    assign pready            = rdy_ff;
    assign prdata            = rdata_ff;
    assign pslverr           = err_ff;
    assign digital_lock_flag = lock_ff;
    assign cal_busy          = busy_ff;

endmodule : pllc_top
`default_nettype wire

// ### pllc_top_asserts.sv
`default_nettype none
module pllc_chk (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pfd_ref_in,
    input wire logic        pfd_fb_in,
    input wire logic        digital_lock_flag,
    input wire logic        cal_busy
);
    // ------------------------------------------------------------------
    // Shadow of staged and active control, raw edge bookkeeping
    // ------------------------------------------------------------------
    logic [6:0] ctrl_ff, nxt_ctrl, act_ff, nxt_act;
    logic [8:0] run_ff, nxt_run, evt_ff, nxt_evt, tgt;
    logic       ref_d_ff, fb_d_ff, ref_r, fb_r, done, go;

    always_comb begin
        done     = psel && penable && pready && pwrite && pstrb[0];
        ref_r    = pfd_ref_in && !ref_d_ff;
        fb_r     = pfd_fb_in && !fb_d_ff;
        go       = done && paddr[11:2] == 10'h1 && pwdata[0] && ctrl_ff[0] && !act_ff[0] && !cal_busy;
        nxt_ctrl = (done && paddr[11:2] == 10'h0) ? pwdata[6:0] : ctrl_ff;
        nxt_act  = (done && paddr[11:2] == 10'h1 && pwdata[0]) ? ctrl_ff : act_ff;
        nxt_run  = (ref_r != fb_r || act_ff[3]) ? 9'h0 : run_ff + 9'(ref_r && run_ff != 9'h1ff);
        nxt_evt  = (ref_r != fb_r || nxt_act != act_ff) ? 9'h0 : evt_ff + 9'(evt_ff != 9'h1ff);
        tgt      = act_ff[6] ? (act_ff[5] ? 9'hff : 9'h40) : (act_ff[5] ? 9'h10 : 9'h05);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff  <= pllc_pkg::CTRL_RST;
            act_ff   <= pllc_pkg::CTRL_RST;
            run_ff   <= 9'h0;
            evt_ff   <= 9'h0;
            ref_d_ff <= 1'b0;
            fb_d_ff  <= 1'b0;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            act_ff   <= nxt_act;
            run_ff   <= nxt_run;
            evt_ff   <= nxt_evt;
            ref_d_ff <= pfd_ref_in;
            fb_d_ff  <= pfd_fb_in;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        !pready ##1 pready;
    endsequence

    property p_apb_wait;
        s_setup ##1 (psel && penable) |-> s_wait;
    endproperty
    property p_ready_one;
        pready |=> !pready;
    endproperty
    property p_err_dec;
        pready |-> pslverr == (paddr[11:4] != 8'h0);
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_lock_run;
        $rose(digital_lock_flag) |-> run_ff >= tgt;
    endproperty
    property p_lock_fall;
        $fell(digital_lock_flag) |-> evt_ff < 9'd400;
    endproperty
    property p_dis_off;
        act_ff[3] && $past(act_ff[3]) |-> !digital_lock_flag;
    endproperty
    property p_cal_go;
        go |-> ##[1:2] cal_busy;
    endproperty
    property p_cal_cause;
        $rose(cal_busy) |-> $past(go) || $past(go, 2);
    endproperty

    a_apb_wait:    assert property (p_apb_wait) else $error("ready not after one wait state");
    a_ready_one:   assert property (p_ready_one) else $error("ready longer than one cycle");
    a_err_dec:     assert property (p_err_dec) else $error("error response wrong for address");
    a_err_ready:   assert property (p_err_ready) else $error("error without ready");
    a_lock_run:    assert property (p_lock_run) else $error("lock before run count");
    a_lock_fall:   assert property (p_lock_fall) else $error("lock lost without cause");
    a_dis_off:     assert property (p_dis_off) else $error("lock while disabled");
    a_cal_go:      assert property (p_cal_go) else $error("calibration did not start");
    a_cal_cause:   assert property (p_cal_cause) else $error("calibration without trigger");
endmodule : pllc_chk

bind pllc_top pllc_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .pfd_ref_in(pfd_ref_in), .pfd_fb_in(pfd_fb_in),
    .digital_lock_flag(digital_lock_flag), .cal_busy(cal_busy));
`default_nettype wire

// ### tb_pll_lock_detect_vco_cal_ctrl.sv
`default_nettype none
module tb_pll_lock_detect_vco_cal_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, nrst, psel, penable, pwrite, pfd_ref_in, pfd_fb_in;
    logic        ref_clk_in = 1'b0;
    logic        pready, pslverr, digital_lock_flag, cal_clk, cal_busy, w;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, m;
    logic [3:0]  pstrb;
    logic [2:0]  rc = 3'h0;
    logic [32:0] e;
    logic [32:0] exp_q[$];
    logic [31:0] msk_q[$];
    int          num_errors, num_checks, n, t;

    pllc_top DUT (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pfd_ref_in(pfd_ref_in), .pfd_fb_in(pfd_fb_in), .ref_clk_in(ref_clk_in),
        .digital_lock_flag(digital_lock_flag), .cal_clk(cal_clk), .cal_busy(cal_busy));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Reference runs at one eighth of the system clock
    always @(posedge clk_sys) begin
        rc <= rc + 3'h1;
        ref_clk_in <= rc[2];
    end

    task automatic summarize();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic fail_out();
        chk(32'h0, 32'h1, "wait bound ran out");
        summarize();
    endtask : fail_out

    // ------------------------------------------------------------------
    // Answer watcher: oldest expectation against each completed transfer
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, e[32]}, "error response");
            chk(prdata & m, e[31:0], "read data");
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] ex,
                       input logic [31:0] mk);
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_out();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] mk);
        apb(1'b0, a, 32'h0, {1'b0, ex}, mk);
    endtask : rd

    task automatic set(input logic [31:0] c);
        apb(1'b1, pllc_pkg::CTRL_OFS, c, 33'h0, 32'h0);
        apb(1'b1, pllc_pkg::UPDATE_OFS, 32'h1, 33'h0, 32'h0);
    endtask : set

    task automatic pulse(input int k, input int gap);
        repeat (k) begin
            pfd_ref_in <= 1'b1;
            repeat (gap) @(posedge clk_sys);
            pfd_fb_in <= 1'b1;
            repeat (4) @(posedge clk_sys);
            pfd_ref_in <= 1'b0;
            pfd_fb_in <= 1'b0;
            repeat (4 + $urandom_range(4)) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
    endtask : pulse

    task automatic rise_cnt(output int c);
        c = 0;
        do begin
            @(negedge clk_sys);
            c++;
        end while (cal_clk !== 1'b0 && c < 400);
        do begin
            @(negedge clk_sys);
            c++;
        end while (cal_clk !== 1'b1 && c < 400);
        if (c >= 400) fail_out();
        @(posedge clk_sys);
    endtask : rise_cnt

    initial begin
        {nrst, psel, penable, pwrite, pfd_ref_in, pfd_fb_in, w} = 7'h0;
        {paddr, pwdata, num_errors, num_checks} = '0;
        pstrb = 4'h1;
        void'($urandom(81014));
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(pllc_pkg::ACTIVE_OFS, 32'(pllc_pkg::CTRL_RST), 32'hff);
        rd(pllc_pkg::STATUS_OFS, 32'h0, 32'h3);
        apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000, 32'h0);
        apb(1'b1, pllc_pkg::ACTIVE_OFS, 32'h7f, 33'h0, 32'h0);
        rd(pllc_pkg::ACTIVE_OFS, 32'h06, 32'hff);
        // Write with byte lane 0 off must leave the staged copy alone
        pstrb <= 4'h0;
        apb(1'b1, pllc_pkg::CTRL_OFS, 32'h7f, 33'h0, 32'h0);
        pstrb <= 4'h1;
        rd(pllc_pkg::CTRL_OFS, 32'(pllc_pkg::CTRL_RST), 32'hff);
        // Lock count for every selector code, window range chosen at random
        for (int s = 0; s < 4; s++) begin
            w = 1'($urandom_range(1));
            set({25'h0, 2'(s), w, 4'he});
            rd(pllc_pkg::STATUS_OFS, 32'h0, 32'h1);
            set({25'h0, 2'(s), w, 4'h6});
            pulse((s == 0 ? 5 : s == 1 ? 16 : s == 2 ? 64 : 255) - 1, 0);
            rd(pllc_pkg::STATUS_OFS, 32'h0, 32'h1);
            pulse(1, 0);
            rd(pllc_pkg::STATUS_OFS, 32'h1, 32'h1);
            chk({31'h0, digital_lock_flag}, 32'h1, "lock output");
        end
        pulse(1, 2);
        rd(pllc_pkg::STATUS_OFS, 32'h1, 32'h1);
        pulse(1, 3);
        rd(pllc_pkg::STATUS_OFS, 32'h0, 32'h1);
        chk({31'h0, digital_lock_flag}, 32'h0, "lock output");
        // Calibration divider ratios
        for (int d = 0; d < 4; d++) begin
            set({29'h1, 2'(d), 1'b0});
            repeat (2) rise_cnt(t);
            rise_cnt(t);
            chk(32'(t), 32'((2 << d) * 8), "calibration clock period");
        end
        // Calibration trigger
        set(32'h0e);
        apb(1'b1, pllc_pkg::CTRL_OFS, 32'h0f, 33'h0, 32'h0);
        rd(pllc_pkg::STATUS_OFS, 32'h0, 32'h2);
        apb(1'b1, pllc_pkg::UPDATE_OFS, 32'h1, 33'h0, 32'h0);
        rd(pllc_pkg::STATUS_OFS, 32'h2, 32'h2);
        chk({31'h0, cal_busy}, 32'h1, "busy output");
        n = 0;
        while (cal_busy !== 1'b0 && n < 6000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 6000) fail_out();
        set(32'h0f);
        rd(pllc_pkg::STATUS_OFS, 32'h0, 32'h2);
        set(32'h0e);
        set(32'h0f);
        rd(pllc_pkg::STATUS_OFS, 32'h2, 32'h2);
        summarize();
    end
endmodule : tb_pll_lock_detect_vco_cal_ctrl
`default_nettype wire
